// ==== tcs_map.vh ====
// Address map, field positions, codes and reset values of the timer
// channel start/stop and unit 0 input select block.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// Register addresses (byte addresses on the native register port)
`define TCS_ADDR_START 32'h40020400
`define TCS_ADDR_STOP 32'h40020404
`define TCS_ADDR_ENABLE 32'h40020408
`define TCS_ADDR_IOSEL 32'h40020474

// Trigger and status register layout (16 bits)
`define TCS_TRIG_W 16
`define TCS_TRIG_RESET 16'h0000
`define TCS_TRIG_LOW_MASK 16'h00FF
`define TCS_TRIG_FULL_MASK 16'hFFFF
`define TCS_CHAN_LSB 0
`define TCS_CHAN_MSB 3
`define TCS_BIT_UP1 9
`define TCS_BIT_UP3 11
`define TCS_READ_ZERO 16'h0000

// Run-enable slots: 0..3 channels, 4 and 5 upper halves of ch1 and ch3
`define TCS_SLOTS 6
`define TCS_SLOT_UP1 4
`define TCS_SLOT_UP3 5

// Unit 0 input/output select register (8 bits)
`define TCS_IOSEL_RESET 8'h00
`define TCS_CH0SRC_MSB 7
`define TCS_CH0SRC_LSB 5
`define TCS_CH0ROUTE_BIT 4
`define TCS_CH2GATE_BIT 3
`define TCS_CH1SRC_MSB 2
`define TCS_CH1SRC_LSB 0

// Channel 0 source code
`define TCS_CH0SRC_PIN 3'h0

// Channel 1 source codes
`define TCS_CH1_PIN_A 3'h0
`define TCS_CH1_EVENT 3'h1
`define TCS_CH1_PIN_B 3'h2
`define TCS_CH1_LOWOSC 3'h4
`define TCS_CH1_SUBCLK 3'h5

// Synchronised external inputs: bit positions in the sync vector
`define TCS_SYNC_W 5
`define TCS_SYN_PIN0 0
`define TCS_SYN_PIN1 1
`define TCS_SYN_EVENT 2
`define TCS_SYN_LOWOSC 3
`define TCS_SYN_SUBCLK 4

`endif

// ==== tcs_sync3.v ====
// Three-stage synchroniser for asynchronous inputs, one lane per bit.
// Assumes inputs may change at any time relative to sys_clk.
`timescale 1ns/1ns
`default_nettype none

module tcs_sync3 #(
   parameter WIDTH = 5
) (
   input wire sys_clk,
   input wire reset_n,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;
   reg [WIDTH-1:0] stage3_r;
   integer i;

   // Shift chain; stage1 feeds only stage2
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_r <= {WIDTH{1'b0}};
         stage2_r <= {WIDTH{1'b0}};
         stage3_r <= {WIDTH{1'b0}};
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // Accept a new level only once stages two and three agree
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         syncOut <= {WIDTH{1'b0}};
      end else begin
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (stage2_r[i] == stage3_r[i]) begin
               syncOut[i] <= stage3_r[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== tcs_trig_pair.v ====
// One self-clearing start/stop trigger pair and its run-enable bit.
// Assumes setStart and setStop are one-cycle pulses from a register write.
`timescale 1ns/1ns
`default_nettype none

module tcs_trig_pair (
   input wire sys_clk,
   input wire reset_n,
   input wire setStart,
   input wire setStop,
   output reg enabled_r,
   output reg startPend_r,
   output reg stopPend_r,
   output reg startPulse_r
);

   reg enabled_nxt;
   reg startPend_nxt;
   reg stopPend_nxt;

   // Next state: stop beats start, a new write beats a self-clear
   always @* begin
      enabled_nxt = enabled_r;
      if (stopPend_r) begin
         enabled_nxt = 1'b0;
      end else if (startPend_r) begin
         enabled_nxt = 1'b1;
      end
      // A trigger lives one cycle: it clears on the edge that moves the enable,
      // so the count start pulse cannot repeat and a following write is not lost
      startPend_nxt = startPend_r;
      if (setStart) begin
         startPend_nxt = 1'b1;
      end else if (startPend_r) begin
         startPend_nxt = 1'b0;
      end
      stopPend_nxt = stopPend_r;
      if (setStop) begin
         stopPend_nxt = 1'b1;
      end else if (stopPend_r) begin
         stopPend_nxt = 1'b0;
      end
   end

   // State registers
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         enabled_r <= 1'b0;
         startPend_r <= 1'b0;
         stopPend_r <= 1'b0;
         startPulse_r <= 1'b0;
      end else begin
         enabled_r <= enabled_nxt;
         startPend_r <= startPend_nxt;
         stopPend_r <= stopPend_nxt;
         startPulse_r <= startPend_r & ~stopPend_r; // Counter init and start
      end
   end

endmodule

`default_nettype wire

// ==== tcs_start_stop.v ====
// Start/stop trigger logic for a four-channel timer unit and the unit 0
// input/output selector, on a native register port.
// Assumes counters, mode registers and outputs live outside; all logic
// runs on sys_clk, which is the timer operating clock.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_map.vh"

// Summary of operation
// - Start bit written one sets channel run-enable; zero does nothing.
// - A started enabled upper half runs as an interval timer while its channel is in 8-bit mode.
// - In 8-bit mode ordinary start bits of ch1/ch3 start only lower half.
// - Start trigger register always reads zero.
// - Stop bit written one clears channel run-enable; zero does nothing.
// - Stop trigger bits clear themselves once the channel or half is stopped.
// - In 8-bit mode upper-half stop bit clears upper-half run-enable of ch1/ch3.
// - In 8-bit mode ordinary stop bits of ch1/ch3 stop only lower half.
// - Stop trigger register always reads zero.
// - Stop register resets to zero; 16-bit writes and low-byte 8-bit writes.
// - Unit 0 select register is 8-bit written and resets to zero.
// - Channel 0 source field zero selects channel 0 pin; other values forbidden.
// - Selector bit 4 routes channel 0 input to field source or event link.
// - Selector bit 3 one forces channel 2 output low; zero passes it.
// - Selector bits 2-0 choose channel 1 pin, event link, low-speed osc or subclock.
// - Start trigger bits clear themselves once the channel or half is enabled.
// - Run-enable status resets to zero, is read-only, moves only by triggers.
module tcs_start_stop (
   input wire sys_clk,
   input wire reset_n,
   input wire regWr,
   input wire regRd,
   input wire regByte,
   input wire [31:0] regAddr,
   input wire [15:0] regWdata,
   output reg [15:0] regRdata,
   input wire [1:0] eightBitMode,
   input wire ch0InputPin,
   input wire ch1InputPin,
   input wire eventLinkIn,
   input wire lowSpeedOscClock,
   input wire subsystemClock,
   input wire ch2TimerOut,
   output reg [3:0] chanRunEnabled,
   output reg [1:0] upperHalfEnabled,
   output reg [3:0] chanCountStart,
   output reg [1:0] upperHalfCountStart,
   output reg [1:0] upperIntervalForce,
   output reg ch0TimerInput,
   output reg ch1TimerInput,
   output reg ch2TimerOutGated
);

   // Write mask for a 16-bit access or a low-byte 8-bit access
   function [15:0] trigMask;
      input byteAccess;
      begin
         if (byteAccess) begin
            trigMask = `TCS_TRIG_LOW_MASK;
         end else begin
            trigMask = `TCS_TRIG_FULL_MASK;
         end
      end
   endfunction

   // Map a 16-bit trigger word onto the six run-enable slots
   function [5:0] trigSlots;
      input [15:0] word;
      input [1:0] mode8;
      begin
         trigSlots[`TCS_CHAN_MSB:`TCS_CHAN_LSB] = word[`TCS_CHAN_MSB:`TCS_CHAN_LSB];
         trigSlots[`TCS_SLOT_UP1] = word[`TCS_BIT_UP1] & mode8[0];
         trigSlots[`TCS_SLOT_UP3] = word[`TCS_BIT_UP3] & mode8[1];
      end
   endfunction

   wire wrStart;
   wire wrStop;
   wire wrIosel;
   wire [15:0] wMask;
   wire [15:0] startWord;
   wire [15:0] stopWord;
   wire [5:0] setStart;
   wire [5:0] setStop;
   wire [5:0] slotEnabled;
   wire [5:0] slotStartPend;
   wire [5:0] slotStopPend;
   wire [5:0] slotStartPulse;
   wire [`TCS_SYNC_W-1:0] syncIn;
   reg [7:0] ioSel_r;
   reg [15:0] rdata_nxt;
   reg ch0In_nxt;
   reg ch1In_nxt;
   wire [2:0] ch0Src;
   wire [2:0] ch1Src;

   // Address decode for writes
   assign wrStart = regWr && (regAddr == `TCS_ADDR_START);
   assign wrStop = regWr && (regAddr == `TCS_ADDR_STOP);
   assign wrIosel = regWr && regByte && (regAddr == `TCS_ADDR_IOSEL);
   assign wMask = trigMask(regByte);

   // Only ones written cause triggers; zeros are ignored
   assign startWord = wrStart ? (regWdata & wMask) : `TCS_TRIG_RESET;
   assign stopWord = wrStop ? (regWdata & wMask) : `TCS_TRIG_RESET;

   // Upper halves only answer in 8-bit mode; ordinary bits drive lower halves
   assign setStart = trigSlots(startWord, eightBitMode);
   assign setStop = trigSlots(stopWord, eightBitMode);

   // One trigger pair per channel and per upper half
   genvar g;
   generate
      for (g = 0; g < `TCS_SLOTS; g = g + 1) begin : gSlot
         tcs_trig_pair uPair (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .setStart(setStart[g]),
            .setStop(setStop[g]),
            .enabled_r(slotEnabled[g]),
            .startPend_r(slotStartPend[g]),
            .stopPend_r(slotStopPend[g]),
            .startPulse_r(slotStartPulse[g])
         );
      end
   endgenerate

   // Selector register: 8-bit writes only
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ioSel_r <= `TCS_IOSEL_RESET;
      end else if (wrIosel) begin
         ioSel_r <= regWdata[7:0];
      end
   end

   // Read mux; trigger registers read zero, unmapped reads zero
   always @* begin
      rdata_nxt = `TCS_READ_ZERO;
      if (regAddr == `TCS_ADDR_START) begin
         rdata_nxt = `TCS_READ_ZERO;
      end else if (regAddr == `TCS_ADDR_STOP) begin
         rdata_nxt = `TCS_READ_ZERO;
      end else if (regAddr == `TCS_ADDR_ENABLE) begin
         rdata_nxt[`TCS_CHAN_MSB:`TCS_CHAN_LSB] = slotEnabled[`TCS_CHAN_MSB:`TCS_CHAN_LSB];
         rdata_nxt[`TCS_BIT_UP1] = slotEnabled[`TCS_SLOT_UP1];
         rdata_nxt[`TCS_BIT_UP3] = slotEnabled[`TCS_SLOT_UP3];
         if (regByte) begin
            rdata_nxt = rdata_nxt & `TCS_TRIG_LOW_MASK;
         end
      end else if (regAddr == `TCS_ADDR_IOSEL) begin
         rdata_nxt = {8'h00, ioSel_r};
      end
   end

   // Read data register
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdata <= `TCS_READ_ZERO;
      end else if (regRd) begin
         regRdata <= rdata_nxt;
      end
   end

   // Synchronise pins and foreign clocks
   tcs_sync3 #(
      .WIDTH(`TCS_SYNC_W)
   ) uSync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn({subsystemClock, lowSpeedOscClock, eventLinkIn, ch1InputPin, ch0InputPin}),
      .syncOut(syncIn)
   );

   assign ch0Src = ioSel_r[`TCS_CH0SRC_MSB:`TCS_CH0SRC_LSB];
   assign ch1Src = ioSel_r[`TCS_CH1SRC_MSB:`TCS_CH1SRC_LSB];

   // Input source selection; forbidden codes give a low input
   always @* begin
      ch0In_nxt = 1'b0;
      if (ioSel_r[`TCS_CH0ROUTE_BIT]) begin
         ch0In_nxt = syncIn[`TCS_SYN_EVENT];
      end else if (ch0Src == `TCS_CH0SRC_PIN) begin
         ch0In_nxt = syncIn[`TCS_SYN_PIN0];
      end
      case (ch1Src)
         `TCS_CH1_PIN_A: ch1In_nxt = syncIn[`TCS_SYN_PIN1];
         `TCS_CH1_PIN_B: ch1In_nxt = syncIn[`TCS_SYN_PIN1];
         `TCS_CH1_EVENT: ch1In_nxt = syncIn[`TCS_SYN_EVENT];
         `TCS_CH1_LOWOSC: ch1In_nxt = syncIn[`TCS_SYN_LOWOSC];
         `TCS_CH1_SUBCLK: ch1In_nxt = syncIn[`TCS_SYN_SUBCLK];
         default: ch1In_nxt = 1'b0;
      endcase
   end

   // Registered outputs
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         chanRunEnabled <= 4'h0;
         upperHalfEnabled <= 2'h0;
         chanCountStart <= 4'h0;
         upperHalfCountStart <= 2'h0;
         upperIntervalForce <= 2'h0;
         ch0TimerInput <= 1'b0;
         ch1TimerInput <= 1'b0;
         ch2TimerOutGated <= 1'b0;
      end else begin
         chanRunEnabled <= slotEnabled[`TCS_CHAN_MSB:`TCS_CHAN_LSB];
         upperHalfEnabled <= {slotEnabled[`TCS_SLOT_UP3], slotEnabled[`TCS_SLOT_UP1]};
         chanCountStart <= slotStartPulse[`TCS_CHAN_MSB:`TCS_CHAN_LSB];
         upperHalfCountStart <= {slotStartPulse[`TCS_SLOT_UP3], slotStartPulse[`TCS_SLOT_UP1]};
         // Enabled upper halves count in interval mode only while their channel is in 8-bit mode
         upperIntervalForce <= {slotEnabled[`TCS_SLOT_UP3], slotEnabled[`TCS_SLOT_UP1]} & eightBitMode;
         ch0TimerInput <= ch0In_nxt;
         ch1TimerInput <= ch1In_nxt;
         ch2TimerOutGated <= ch2TimerOut & ~ioSel_r[`TCS_CH2GATE_BIT];
      end
   end

endmodule

`default_nettype wire

// ==== tcs_start_stop_props.sv ====
// Port-level assertions for the timer start/stop and selector block.
// Assumes one sys_clk domain and the active-low reset reset_n.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_map.vh"
module tcs_start_stop_props (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic regByte,
   input wire logic [31:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] regRdata,
   input wire logic [3:0] chanRunEnabled,
   input wire logic [3:0] chanCountStart,
   input wire logic [1:0] upperHalfCountStart,
   input wire logic ch2TimerOut,
   input wire logic ch2TimerOutGated
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // Decoded trigger writes and the bits they carry
   wire logic startWr = regWr && regAddr == `TCS_ADDR_START;
   wire logic stopWr = regWr && regAddr == `TCS_ADDR_STOP;
   wire logic trigRd = regRd && (regAddr == `TCS_ADDR_START || regAddr == `TCS_ADDR_STOP);
   wire logic [3:0] startBits = startWr ? regWdata[3:0] : 4'h0;
   wire logic [3:0] stopBits = stopWr ? regWdata[3:0] : 4'h0;
   wire logic [1:0] upBits = startWr ? {regWdata[11], regWdata[9]} : 2'h0;

   start_sets_a: assert property (startWr |-> ##3 (chanRunEnabled & $past(startBits, 3)) == $past(startBits, 3))
      else $error("start write did not enable its channels");
   stop_clears_a: assert property (stopWr |-> ##3 (chanRunEnabled & $past(stopBits, 3)) == 4'h0)
      else $error("stop write did not stop its channels");
   count_cause_a: assert property ((chanCountStart & ~$past(startBits, 3)) == 4'h0)
      else $error("count start pulse without a start write");
   upper_cause_a: assert property ((upperHalfCountStart & ~$past(upBits, 3)) == 2'h0)
      else $error("upper half started without its own start bit");
   trig_read_zero_a: assert property (trigRd |=> regRdata == 16'h0000)
      else $error("trigger register read not zero");
   status_moves_a: assert property ($changed(chanRunEnabled) |-> $past(startWr || stopWr, 3))
      else $error("run-enable moved without a trigger write");
   status_read_a: assert property (regRd && !regByte && regAddr == `TCS_ADDR_ENABLE |=> regRdata[3:0] == chanRunEnabled)
      else $error("status read disagrees with run-enable");
   ch2_gate_a: assert property (ch2TimerOutGated |-> $past(ch2TimerOut))
      else $error("gated channel 2 output high without source");

   // Main scenarios reached
   cover property (chanCountStart[0]);
   cover property (upperHalfCountStart[1]);
   cover property (stopWr ##1 startWr);
endmodule

bind tcs_start_stop tcs_start_stop_props tcs_start_stop_props_inst (.sys_clk(sys_clk), .reset_n(reset_n),
   .regWr(regWr), .regRd(regRd), .regByte(regByte), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .chanRunEnabled(chanRunEnabled), .chanCountStart(chanCountStart),
   .upperHalfCountStart(upperHalfCountStart), .ch2TimerOut(ch2TimerOut), .ch2TimerOutGated(ch2TimerOutGated));
`default_nettype wire

// ==== tb_top.sv ====
// Directed regression of the timer start/stop and selector block.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_map.vh"
module tb_top;
   logic sys_clk, reset_n, regWr, regRd, regByte, ch2TimerOut;
   logic [31:0] regAddr;
   logic [15:0] regWdata, regRdata, rdv;
   logic [1:0] eightBitMode, upperHalfEnabled, upperHalfCountStart, upperIntervalForce;
   logic [3:0] chanRunEnabled, chanCountStart;
   logic [4:0] ins;
   logic ch0TimerInput, ch1TimerInput, ch2TimerOutGated;
   int errors = 0;
   int comparisons = 0;
   int starts = 0;
   int uppers = 0;
   // Packed {select code, input levels, expected ch0 and ch1 inputs}
   logic [15:0] selTab [14] = '{16'h000F, 16'h0070, 16'h0091, 16'h00EE, 16'h0109, 16'h0176, 16'h0221,
      16'h025E, 16'h02C1, 16'h02BE, 16'h0812, 16'h086D, 16'h01FE, 16'h107D};

   tcs_start_stop tcs_start_stop_inst (.sys_clk(sys_clk), .reset_n(reset_n), .regWr(regWr), .regRd(regRd),
      .regByte(regByte), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .eightBitMode(eightBitMode), .ch0InputPin(ins[0]), .ch1InputPin(ins[1]), .eventLinkIn(ins[2]),
      .lowSpeedOscClock(ins[3]), .subsystemClock(ins[4]), .ch2TimerOut(ch2TimerOut),
      .chanRunEnabled(chanRunEnabled), .upperHalfEnabled(upperHalfEnabled), .chanCountStart(chanCountStart),
      .upperHalfCountStart(upperHalfCountStart), .upperIntervalForce(upperIntervalForce),
      .ch0TimerInput(ch0TimerInput), .ch1TimerInput(ch1TimerInput), .ch2TimerOutGated(ch2TimerOutGated));

   // Count start pulses of channel 0 and of the channel 1 upper half
   always @(posedge sys_clk) begin
      if (chanCountStart[0] === 1'b1) starts++;
      if (upperHalfCountStart[0] === 1'b1) uppers++;
   end

   // Compare and count
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // One write; hold keeps the strobe up for a back-to-back write,
   // otherwise the strobe stays low for one cycle before the next call
   task automatic wr(logic [31:0] a, logic [15:0] d, logic b, logic hold = 1'b0);
      regWr = 1'b1;
      regAddr = a;
      regWdata = d;
      regByte = b;
      @(negedge sys_clk);
      if (!hold) begin
         regWr = 1'b0;
         @(negedge sys_clk);
      end
   endtask
   // One read; the data is taken a cycle after the strobe
   task automatic rd(logic [31:0] a, logic b);
      regRd = 1'b1;
      regAddr = a;
      regByte = b;
      @(negedge sys_clk);
      regRd = 1'b0;
      idle(1);
      rdv = regRdata;
   endtask
   task automatic conclude();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      conclude();
   end
   // Test sequence
   initial begin
      reset_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regByte = 1'b0;
      regAddr = 32'h00000000;
      regWdata = 16'h0000;
      eightBitMode = 2'h0;
      ins = 5'h00;
      ch2TimerOut = 1'b0;
      idle(16);
      reset_n = 1'b1;
      rd(`TCS_ADDR_ENABLE, 1'b0);
      chk("enable reg", rdv, `TCS_TRIG_RESET);
      rd(`TCS_ADDR_STOP, 1'b0);
      chk("stop reg", rdv, `TCS_TRIG_RESET);
      rd(`TCS_ADDR_IOSEL, 1'b1);
      chk("select reg", rdv, 16'h0000);
      $display("test reset done");
      idle(4);
      wr(`TCS_ADDR_START, 16'h000F, 1'b0);
      idle(6);
      chk("run", chanRunEnabled, 16'h000F);
      chk("ch0 starts", 16'(starts), 16'h0001);
      rd(`TCS_ADDR_START, 1'b0);
      chk("start reg", rdv, 16'h0000);
      wr(`TCS_ADDR_START, 16'hFF00, 1'b1);
      wr(`TCS_ADDR_STOP, 16'h0000, 1'b0);
      wr(`TCS_ADDR_STOP, 16'h0006, 1'b1);
      idle(6);
      chk("run", chanRunEnabled, 16'h0009);
      rd(`TCS_ADDR_STOP, 1'b0);
      chk("stop reg", rdv, 16'h0000);
      wr(`TCS_ADDR_STOP, 16'h0009, 1'b0, 1'b1);
      wr(`TCS_ADDR_START, 16'h0001, 1'b0, 1'b1);
      wr(`TCS_ADDR_STOP, 16'h0001, 1'b0);
      idle(6);
      chk("run", chanRunEnabled, 16'h0000);
      wr(`TCS_ADDR_START, 16'h0001, 1'b0);
      idle(6);
      chk("run", chanRunEnabled, 16'h0001);
      chk("ch0 starts", 16'(starts), 16'h0003);
      wr(`TCS_ADDR_STOP, 16'h0001, 1'b0);
      rd(32'h40020500, 1'b0);
      chk("unmapped", rdv, 16'h0000);
      $display("test start stop done");
      eightBitMode = 2'h3;
      wr(`TCS_ADDR_START, 16'h0A00, 1'b0);
      idle(6);
      chk("upper", upperHalfEnabled, 16'h0003);
      chk("force", upperIntervalForce, 16'h0003);
      chk("upper starts", 16'(uppers), 16'h0001);
      wr(`TCS_ADDR_START, 16'h000A, 1'b0);
      idle(6);
      chk("run", chanRunEnabled, 16'h000A);
      chk("upper starts", 16'(uppers), 16'h0001);
      wr(`TCS_ADDR_STOP, 16'h000A, 1'b0);
      idle(6);
      chk("upper", upperHalfEnabled, 16'h0003);
      wr(`TCS_ADDR_STOP, 16'h0A00, 1'b0);
      idle(6);
      chk("upper", upperHalfEnabled, 16'h0000);
      chk("force", upperIntervalForce, 16'h0000);
      eightBitMode = 2'h0;
      wr(`TCS_ADDR_START, 16'h0200, 1'b0);
      idle(6);
      chk("upper", upperHalfEnabled, 16'h0000);
      chk("upper starts", 16'(uppers), 16'h0001);
      $display("test eight bit done");
      wr(`TCS_ADDR_IOSEL, 16'h0008, 1'b0);
      rd(`TCS_ADDR_IOSEL, 1'b1);
      chk("select reg", rdv, 16'h0000);
      wr(`TCS_ADDR_IOSEL, 16'h0008, 1'b1);
      rd(`TCS_ADDR_IOSEL, 1'b1);
      chk("select reg", rdv, 16'h0008);
      ch2TimerOut = 1'b1;
      idle(3);
      chk("ch2 out", ch2TimerOutGated, 16'h0000);
      wr(`TCS_ADDR_IOSEL, 16'h0000, 1'b1);
      idle(3);
      chk("ch2 out", ch2TimerOutGated, 16'h0001);
      for (int i = 0; i < 14; i++) begin
         wr(`TCS_ADDR_IOSEL, {8'h00, selTab[i][14:7]}, 1'b1);
         ins = selTab[i][6:2];
         idle(8);
         chk("inputs", {ch0TimerInput, ch1TimerInput}, selTab[i][1:0]);
      end
      $display("test select done");
      conclude();
   end
endmodule
`default_nettype wire
